// file: core/rtc_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 4-bit register index, 8-bit data, 25 MHz system clock
// Notes: included by the control top and the calendar modules
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define RTC_OFF_CTRL 4'h0
`define RTC_OFF_FLAG 4'h1
`define RTC_OFF_R64 4'h2
`define RTC_OFF_CNT0 4'h3
`define RTC_OFF_CNT_LAST 4'h9
`define RTC_OFF_ALM0 4'ha

// ****************************************
// field positions
// ****************************************
`define RTC_CTRL_PEF 7
`define RTC_CTRL_PSEL_HI 6
`define RTC_CTRL_PSEL_LO 4
`define RTC_CTRL_OSC 3
`define RTC_CTRL_ROUND 2
`define RTC_CTRL_DRST 1
`define RTC_CTRL_RUN 0
`define RTC_FLAG_CF 7
`define RTC_FLAG_CIE 4
`define RTC_FLAG_AIE 3
`define RTC_FLAG_AF 0
`define RTC_ALM_EN 7

// ****************************************
// reset values
// ****************************************
`define RTC_CTRL_RST 8'h09
`define RTC_FLAG_RST 8'h00
`define RTC_ALM_RST 8'h00

// ****************************************
// timing
// ****************************************
`define RTC_CLK_NS 40
`define RTC_ROUND_LIMIT_NS 91600
`define RTC_ROUND_LIMIT_CYC (`RTC_ROUND_LIMIT_NS / `RTC_CLK_NS)
`define RTC_DIV_W 16
`define RTC_R64_LO 9
`define RTC_SEC_BITS 15

`endif

// file: core/rtc_pkg.sv
// Purpose: shared types of the calendar control block
// Assumes: binary counter fields
// Notes: constants live in rtc_cfg.svh
package rtc_pkg;

  typedef enum logic [2:0] {
    rtc_per_none,
    rtc_per_256th,
    rtc_per_64th,
    rtc_per_16th,
    rtc_per_4th,
    rtc_per_half,
    rtc_per_1s,
    rtc_per_2s
  } rtc_period_t;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [4:0] hour;
    logic [2:0] wkday;
    logic [4:0] date;
    logic [3:0] month;
    logic [6:0] year;
  } rtc_time_t;

endpackage : rtc_pkg

// file: core/rtc_cal_if.sv
// Purpose: links control top with calendar and alarm modules
// Assumes: one clock domain
// Notes: wr_sel indexes counter or alarm field
`timescale 1ns/100ps
interface rtc_cal_if;
  logic sec_tick;
  logic round;
  logic run;
  logic cnt_wr;
  logic alm_wr;
  logic [2:0] wr_sel;
  logic [7:0] wr_data;
  rtc_pkg::rtc_time_t now;
  logic sec_inc;
  logic match;
  logic [5:0][7:0] alm_regs;

  modport ctrl (
    output sec_tick, round, run, cnt_wr, alm_wr, wr_sel, wr_data,
    input now, sec_inc, match, alm_regs
  );
  modport cal (
    input sec_tick, round, run, cnt_wr, wr_sel, wr_data,
    output now, sec_inc
  );
  modport alm (
    input alm_wr, wr_sel, wr_data, now,
    output match, alm_regs
  );
endinterface : rtc_cal_if

// file: core/rtc_calendar.sv
// Purpose: seconds to year counters with rounding
// Assumes: binary fields, 31-day months
// Notes: writes ignored while counting
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_calendar (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control link
  rtc_cal_if.cal cal
);

  // carry in bit 7, next value in bits 6:0
  function automatic logic [7:0] step(input logic [6:0] v,
    input logic [6:0] lo, input logic [6:0] hi, input logic en);
    if (!en)
      step = {1'b0, v};
    else if (v >= hi)
      step = {1'b1, lo};
    else
      step = {1'b0, 7'(v + 7'h01)};
  endfunction : step

  rtc_pkg::rtc_time_t now;
  wire logic sec_en = cal.run && cal.sec_tick;
  wire logic round_up = cal.round && (now.sec >= 7'h1e);
  wire logic [7:0] s_st = step(now.sec, 7'h00, 7'h3b, sec_en);
  wire logic min_en = cal.round ? round_up : s_st[7];
  wire logic [7:0] m_st = step(now.min, 7'h00, 7'h3b, min_en);
  wire logic [7:0] h_st = step({2'b00, now.hour}, 7'h00, 7'h17,
    m_st[7]);
  wire logic [7:0] w_st = step({4'h0, now.wkday}, 7'h00, 7'h06,
    h_st[7]);
  wire logic [7:0] d_st = step({2'b00, now.date}, 7'h01, 7'h1f,
    h_st[7]);
  wire logic [7:0] mo_st = step({3'b000, now.month}, 7'h01, 7'h0c,
    d_st[7]);
  wire logic [7:0] y_st = step(now.year, 7'h00, 7'h63, mo_st[7]);
  wire logic wr_ok = cal.cnt_wr && !cal.run;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      now <= '{7'h00, 7'h00, 5'h00, 3'h0, 5'h01, 4'h1, 7'h00};
    end
    else if (wr_ok)
    begin
      case (cal.wr_sel)
        3'h0: now.sec <= cal.wr_data[6:0];
        3'h1: now.min <= cal.wr_data[6:0];
        3'h2: now.hour <= cal.wr_data[4:0];
        3'h3: now.wkday <= cal.wr_data[2:0];
        3'h4: now.date <= cal.wr_data[4:0];
        3'h5: now.month <= cal.wr_data[3:0];
        3'h6: now.year <= cal.wr_data[6:0];
        default: now <= now;
      endcase
    end
    else
    begin
      now.sec <= cal.round ? 7'h00 : s_st[6:0];
      now.min <= m_st[6:0];
      now.hour <= h_st[4:0];
      now.wkday <= w_st[2:0];
      now.date <= d_st[4:0];
      now.month <= mo_st[3:0];
      now.year <= y_st[6:0];
    end
  end

  assign cal.now = now;
  assign cal.sec_inc = sec_en || cal.round;

endmodule : rtc_calendar

// file: core/rtc_alarm.sv
// Purpose: alarm field registers and match detection
// Assumes: enable bit 7 in each field
// Notes: match is a one-cycle pulse on entering a match
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_alarm (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control link
  rtc_cal_if.alm alm
);

  logic [5:0][7:0] regs;
  logic match_q;
  wire logic [5:0] en;
  wire logic [5:0] eq;

  assign eq[0] = regs[0][6:0] == alm.now.sec;
  assign eq[1] = regs[1][6:0] == alm.now.min;
  assign eq[2] = regs[2][4:0] == alm.now.hour;
  assign eq[3] = regs[3][2:0] == alm.now.wkday;
  assign eq[4] = regs[4][4:0] == alm.now.date;
  assign eq[5] = regs[5][3:0] == alm.now.month;

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_en
      assign en[i] = regs[i][`RTC_ALM_EN];
    end
  endgenerate

  // no enabled field means no alarm at all
  wire logic match_now = (|en) && (&(~en | eq));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      regs <= {6{`RTC_ALM_RST}};
      match_q <= 1'b0;
    end
    else
    begin
      if (alm.alm_wr)
        regs[alm.wr_sel] <= alm.wr_data;
      match_q <= match_now;
    end
  end

  assign alm.match = match_now && !match_q;
  assign alm.alm_regs = regs;

endmodule : rtc_alarm

// file: core/rtc_ctrl_top.sv
// Purpose: run, round and periodic control of the calendar clock
// Assumes: crystal level sampled on clk_i; manual reset synchronous
// Notes: registers reached through a plain strobe port
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_ctrl_top (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic manual_rst_i,
  // crystal
  input wire logic calendar_crystal_input_i,
  output logic oscillator_enable_o,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  // interrupt requests
  output logic periodic_irq_o,
  output logic alarm_irq_o,
  output logic carry_irq_o
);

  // ****************************************
  // helpers
  // ****************************************
  // low divider bits that must be all ones for one interval
  function automatic logic [`RTC_DIV_W-1:0] period_mask(
    input rtc_pkg::rtc_period_t sel);
    case (sel)
      rtc_pkg::rtc_per_256th: period_mask = 16'h007f;
      rtc_pkg::rtc_per_64th: period_mask = 16'h01ff;
      rtc_pkg::rtc_per_16th: period_mask = 16'h07ff;
      rtc_pkg::rtc_per_4th: period_mask = 16'h1fff;
      rtc_pkg::rtc_per_half: period_mask = 16'h3fff;
      rtc_pkg::rtc_per_1s: period_mask = 16'h7fff;
      rtc_pkg::rtc_per_2s: period_mask = 16'hffff;
      default: period_mask = 16'h0000;
    endcase
  endfunction : period_mask

  function automatic logic all_ones(input logic [`RTC_DIV_W-1:0] v,
    input logic [`RTC_DIV_W-1:0] m);
    all_ones = (m != 16'h0000) && ((v & m) == m);
  endfunction : all_ones

  // ****************************************
  // state
  // ****************************************
  logic periodic_flag;
  rtc_pkg::rtc_period_t period_select;
  logic oscillator_enable;
  logic counter_run;
  logic carry_flag;
  logic carry_irq_enable;
  logic alarm_interrupt_enable;
  logic alarm_flag;
  logic [`RTC_DIV_W-1:0] div;
  logic xs1;
  logic xs2;
  logic xs3;
  logic xstable;
  logic rd_pend;
  logic [7:0] rdata;

  rtc_cal_if link ();

  // ****************************************
  // crystal edge detection
  // ****************************************
  // a level counts only once second and third stage agree
  wire logic xagree = xs2 == xs3;
  wire logic xrise = xagree && xs3 && !xstable;
  wire logic osc_tick = xrise && oscillator_enable;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
      xstable <= 1'b0;
    end
    else
    begin
      xs1 <= calendar_crystal_input_i;
      xs2 <= xs1;
      xs3 <= xs2;
      if (xagree)
        xstable <= xs3;
    end
  end

  // ****************************************
  // register decode
  // ****************************************
  wire logic sel_ctrl = addr_i == `RTC_OFF_CTRL;
  wire logic sel_flag = addr_i == `RTC_OFF_FLAG;
  wire logic sel_r64 = addr_i == `RTC_OFF_R64;
  wire logic sel_cnt = (addr_i >= `RTC_OFF_CNT0) &&
    (addr_i <= `RTC_OFF_CNT_LAST);
  wire logic sel_alm = addr_i >= `RTC_OFF_ALM0;
  wire logic [3:0] cnt_idx = addr_i - `RTC_OFF_CNT0;
  wire logic [3:0] alm_idx = addr_i - `RTC_OFF_ALM0;
  wire logic wr_ctrl = we_i && sel_ctrl;
  wire logic wr_flag = we_i && sel_flag;
  wire logic rd_count = re_i && (sel_r64 || sel_cnt);

  // action bits are pulses and never stored
  wire logic round_pulse = wr_ctrl && wdata_i[`RTC_CTRL_ROUND];
  wire logic drst_pulse = wr_ctrl && wdata_i[`RTC_CTRL_DRST];

  // ****************************************
  // divider chain and 64 Hz counter
  // ****************************************
  wire logic [`RTC_DIV_W-1:0] sec_mask = 16'h7fff;
  wire logic [`RTC_DIV_W-1:0] r64_mask = 16'h01ff;
  wire logic sec_tick = osc_tick && all_ones(div, sec_mask);
  wire logic r64_carry = osc_tick && all_ones(div, r64_mask);
  wire logic period_hit = osc_tick &&
    all_ones(div, period_mask(period_select));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      div <= 16'h0000;
    else if (round_pulse || drst_pulse)
      div <= 16'h0000;
    else if (osc_tick)
      div <= div + 16'h0001;
  end

  // ****************************************
  // calendar and alarm
  // ****************************************
  assign link.sec_tick = sec_tick;
  assign link.round = round_pulse;
  assign link.run = counter_run;
  assign link.cnt_wr = we_i && sel_cnt;
  assign link.alm_wr = we_i && sel_alm;
  assign link.wr_sel = sel_alm ? alm_idx[2:0] : cnt_idx[2:0];
  assign link.wr_data = wdata_i;

  rtc_calendar u_cal (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cal(link.cal)
  );

  rtc_alarm u_alm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .alm(link.alm)
  );

  // ****************************************
  // control register
  // ****************************************
  // set beats a same-cycle clear; writing 1 keeps the flag as is
  wire logic next_periodic_flag = period_hit ||
    (periodic_flag && !(wr_ctrl && !wdata_i[`RTC_CTRL_PEF]));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      periodic_flag <= 1'(`RTC_CTRL_RST >> `RTC_CTRL_PEF);
      period_select <= rtc_pkg::rtc_per_none;
      oscillator_enable <= 1'(`RTC_CTRL_RST >> `RTC_CTRL_OSC);
      counter_run <= 1'(`RTC_CTRL_RST >> `RTC_CTRL_RUN);
    end
    else if (manual_rst_i)
    begin
      // oscillator and run bits survive a manual reset
      periodic_flag <= 1'b0;
      period_select <= rtc_pkg::rtc_per_none;
    end
    else
    begin
      // no standby path here: contents simply hold
      periodic_flag <= next_periodic_flag;
      if (wr_ctrl)
      begin
        period_select <= rtc_pkg::rtc_period_t'(
          wdata_i[`RTC_CTRL_PSEL_HI:`RTC_CTRL_PSEL_LO]);
        oscillator_enable <= wdata_i[`RTC_CTRL_OSC];
        counter_run <= wdata_i[`RTC_CTRL_RUN];
      end
    end
  end

  // ****************************************
  // flag register
  // ****************************************
  // carry seen in the read cycle or the one after it
  wire logic carry_ev = r64_carry || link.sec_inc;
  wire logic carry_set = carry_ev && (rd_count || rd_pend);
  wire logic next_carry_flag = carry_set ||
    (carry_flag && !(wr_flag && !wdata_i[`RTC_FLAG_CF]));
  wire logic next_alarm_flag = link.match ||
    (alarm_flag && !(wr_flag && !wdata_i[`RTC_FLAG_AF]));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      carry_flag <= 1'b0;
      carry_irq_enable <= 1'b0;
      alarm_interrupt_enable <= 1'b0;
      alarm_flag <= 1'b0;
      rd_pend <= 1'b0;
    end
    else
    begin
      rd_pend <= rd_count;
      carry_flag <= next_carry_flag;
      if (manual_rst_i)
      begin
        carry_irq_enable <= 1'b0;
        alarm_interrupt_enable <= 1'b0;
        alarm_flag <= 1'b0;
      end
      else
      begin
        alarm_flag <= next_alarm_flag;
        if (wr_flag)
        begin
          carry_irq_enable <= wdata_i[`RTC_FLAG_CIE];
          alarm_interrupt_enable <= wdata_i[`RTC_FLAG_AIE];
        end
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // action bits always read back as zero
  wire logic [7:0] ctrl_word = {periodic_flag, period_select,
    oscillator_enable, 1'b0, 1'b0, counter_run};
  wire logic [7:0] flag_word = {carry_flag, 2'b00, carry_irq_enable,
    alarm_interrupt_enable, 2'b00, alarm_flag};
  wire rtc_pkg::rtc_time_t now = link.now;
  logic [7:0] cnt_word;
  logic [7:0] read_word;

  always_comb
  begin
    case (cnt_idx[2:0])
      3'h0: cnt_word = {1'b0, now.sec};
      3'h1: cnt_word = {1'b0, now.min};
      3'h2: cnt_word = {3'b000, now.hour};
      3'h3: cnt_word = {5'h00, now.wkday};
      3'h4: cnt_word = {3'b000, now.date};
      3'h5: cnt_word = {4'h0, now.month};
      3'h6: cnt_word = {1'b0, now.year};
      default: cnt_word = 8'h00;
    endcase
  end

  always_comb
  begin
    if (sel_ctrl)
      read_word = ctrl_word;
    else if (sel_flag)
      read_word = flag_word;
    else if (sel_r64)
      read_word = {2'b00, div[`RTC_SEC_BITS-1:`RTC_R64_LO]};
    else if (sel_cnt)
      read_word = cnt_word;
    else
      read_word = link.alm_regs[alm_idx[2:0]];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata <= 8'h00;
    else
      rdata <= re_i ? read_word : 8'h00;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata_o = rdata;
  assign oscillator_enable_o = oscillator_enable;
  assign periodic_irq_o = periodic_flag;
  assign alarm_irq_o = alarm_flag && alarm_interrupt_enable;
  assign carry_irq_o = carry_flag && carry_irq_enable;

endmodule : rtc_ctrl_top

// file: test/rtc_ctrl_chk.sv
// Purpose: port checks of the run, round and periodic control
// Assumes: one clock domain, rst_i async active high
// Notes: bound to rtc_ctrl_top after the module
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_ctrl_chk (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic manual_rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [7:0] rdata_o,
  // levels
  input wire logic oscillator_enable_o,
  input wire logic periodic_irq_o,
  input wire logic alarm_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****
  // steps of a control access
  // ****
  sequence s_ctrl_wr;
    we_i && addr_i == `RTC_OFF_CTRL && !manual_rst_i;
  endsequence
  sequence s_ctrl_rd;
    re_i && addr_i == `RTC_OFF_CTRL;
  endsequence

  a_rdata_idle_zero: assert property (
    !re_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_pulse_bits_zero: assert property (
    s_ctrl_rd |=> rdata_o[2:1] == 2'b00)
    else $error("round or divider reset bit read as one");
  a_osc_read_match: assert property (
    s_ctrl_rd |=> rdata_o[3] == oscillator_enable_o)
    else $error("oscillator bit read differs from pin");
  a_osc_follows_wr: assert property (
    s_ctrl_wr |=> oscillator_enable_o == $past(wdata_i[3]))
    else $error("oscillator enable did not follow write");
  a_osc_holds_idle: assert property (
    !(we_i && addr_i == `RTC_OFF_CTRL) |=> $stable(oscillator_enable_o))
    else $error("oscillator enable changed without a write");
  a_pef_holds_set: assert property (
    periodic_irq_o && !(we_i && addr_i == `RTC_OFF_CTRL) && !manual_rst_i
    |=> periodic_irq_o)
    else $error("periodic flag dropped without a clear");
  a_pef_manual_clr: assert property (
    manual_rst_i |=> !periodic_irq_o)
    else $error("periodic flag survived manual reset");
  a_aie_manual_clr: assert property (
    manual_rst_i |=> !alarm_irq_o)
    else $error("alarm request survived manual reset");
  a_pef_needs_osc: assert property (
    $rose(periodic_irq_o) |-> $past(oscillator_enable_o))
    else $error("periodic flag set with oscillator halted");
endmodule : rtc_ctrl_chk

bind rtc_ctrl_top rtc_ctrl_chk u_rtc_ctrl_chk (
  .clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
  .rdata_o(rdata_o), .oscillator_enable_o(oscillator_enable_o),
  .periodic_irq_o(periodic_irq_o), .alarm_irq_o(alarm_irq_o)
);

// file: test/tb_rtc_ctrl_top.sv
// Purpose: self-checking bench of the control block
// Assumes: crystal driven by the bench as slow pulses
// Notes: select codes 5 and 7 are only checked for silence
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module tb_rtc_ctrl_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic mrst = 1'b0;
  logic xtal = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [7:0] rdata_o;
  logic osc;
  logic pirq;
  logic airq;
  logic cirq;
  int mismatches = 0;
  int n_checks = 0;
  int s;
  logic [7:0] m_ctrl;
  logic [7:0] m_min;
  logic [7:0] rd_v;
  logic [7:0] v;

  always #20 clk_i = ~clk_i;

  rtc_ctrl_top u_rtc_ctrl_top (
    .clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(mrst),
    .calendar_crystal_input_i(xtal), .oscillator_enable_o(osc),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .periodic_irq_o(pirq), .alarm_irq_o(airq),
    .carry_irq_o(cirq)
  );

  // ****
  // bus, crystal and compare tasks
  // ****
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    chk8(rdata_o, exp);
  endtask : chk_rd

  // action bits never stored; flag only kept or cleared
  task automatic wctrl(input logic [7:0] d);
    wr(`RTC_OFF_CTRL, d);
    m_ctrl = {m_ctrl[7] & d[7], d[6:3], 2'b00, d[0]};
  endtask : wctrl

  // 3 high, 3 low: the slowest legal pulse costs too many cycles
  task automatic ticks(input int n);
    @(posedge clk_i);
    repeat (n)
    begin
      xtal <= 1'b1;
      repeat (3) @(posedge clk_i);
      xtal <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask : ticks

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  initial
  begin
    repeat (95000) @(posedge clk_i);
    mismatches++;
    results();
  end

  // ****
  // tests
  // ****
  initial
  begin
    s = $urandom(32'h7276);
    m_ctrl = 8'h09;
    m_min = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd(`RTC_OFF_CTRL, 8'h09);
    chk8({7'h00, osc}, 8'h01);
    $display("test reset done");
    // no crystal pulses yet, so the flag cannot set
    repeat (8)
    begin
      v = 8'($urandom);
      wctrl(v);
      chk_rd(`RTC_OFF_CTRL, m_ctrl);
      chk8({7'h00, osc}, {7'h00, m_ctrl[3]});
    end
    $display("test access done");
    repeat (4)
    begin
      wctrl(8'($urandom));
      @(posedge clk_i);
      mrst <= 1'b1;
      @(posedge clk_i);
      mrst <= 1'b0;
      m_ctrl = m_ctrl & 8'h09;
      chk_rd(`RTC_OFF_CTRL, m_ctrl);
    end
    $display("test manual reset done");
    wctrl(8'h08);
    for (int i = 0; i < 3; i++)
    begin
      s = (i == 0) ? 29 : (i == 1) ? 30 : $urandom_range(59);
      wr(`RTC_OFF_CNT0, 8'(s));
      wctrl(8'h0c);
      m_min = m_min + 8'(s >= 30);
      chk_rd(`RTC_OFF_CNT0, 8'h00);
      chk_rd(`RTC_OFF_CNT0 + 4'h1, m_min);
    end
    wctrl(8'h09);
    wr(`RTC_OFF_CNT0, 8'h11);
    chk_rd(`RTC_OFF_CNT0, 8'h00);
    $display("test round done");
    wctrl(8'h5a);
    ticks(520);
    chk_rd(`RTC_OFF_R64, 8'h01);
    chk8({7'h00, pirq}, 8'h00);
    wctrl(8'h7a);
    chk_rd(`RTC_OFF_R64, 8'h00);
    ticks(520);
    chk8({7'h00, pirq}, 8'h00);
    wctrl(8'h0c);
    chk_rd(`RTC_OFF_R64, 8'h00);
    wctrl(8'h12);
    ticks(520);
    chk_rd(`RTC_OFF_R64, 8'h00);
    chk8({7'h00, pirq}, 8'h00);
    wctrl(8'h0a);
    ticks(256);
    chk8({7'h00, pirq}, 8'h00);
    $display("test divider done");
    for (int p = 1; p <= 4; p++)
    begin
      wctrl(8'h0a | 8'(p << 4));
      ticks((1 << (2 * p + 5)) - 1);
      chk8({7'h00, pirq}, 8'h00);
      ticks(1);
      chk8({7'h00, pirq}, 8'h01);
      m_ctrl[7] = 1'b1;
      wctrl(8'h88 | 8'(p << 4));
      chk_rd(`RTC_OFF_CTRL, m_ctrl);
      wctrl(8'h08 | 8'(p << 4));
      chk_rd(`RTC_OFF_CTRL, m_ctrl);
      chk8({7'h00, pirq}, 8'h00);
    end
    $display("test periodic done");
    wr(`RTC_OFF_FLAG, 8'h08);
    wctrl(8'h08);
    wr(`RTC_OFF_CNT0, 8'h0a);
    wr(`RTC_OFF_ALM0 + 4'h1, 8'h80 | (m_min + 8'h01));
    wr(`RTC_OFF_ALM0, 8'h8a);
    chk_rd(`RTC_OFF_FLAG, 8'h08);
    chk8({7'h00, airq}, 8'h00);
    wr(`RTC_OFF_ALM0 + 4'h1, 8'h00);
    chk_rd(`RTC_OFF_FLAG, 8'h09);
    chk8({7'h00, airq}, 8'h01);
    wr(`RTC_OFF_FLAG, 8'h09);
    chk_rd(`RTC_OFF_FLAG, 8'h09);
    wr(`RTC_OFF_FLAG, 8'h08);
    chk_rd(`RTC_OFF_FLAG, 8'h08);
    chk8({7'h00, airq}, 8'h00);
    $display("test alarm done");
    wctrl(8'h0a);
    wr(`RTC_OFF_FLAG, 8'h10);
    ticks(511);
    // reads back to back while the 64 Hz step lands
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= `RTC_OFF_R64;
    xtal <= 1'b1;
    repeat (8) @(posedge clk_i);
    re_i <= 1'b0;
    xtal <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk_rd(`RTC_OFF_FLAG, 8'h90);
    chk8({7'h00, cirq}, 8'h01);
    chk_rd(`RTC_OFF_R64, 8'h01);
    wr(`RTC_OFF_FLAG, 8'h10);
    chk_rd(`RTC_OFF_FLAG, 8'h10);
    chk8({7'h00, cirq}, 8'h00);
    $display("test carry done");
    results();
  end
endmodule : tb_rtc_ctrl_top
